// ---- design/dfs_pkg.sv ----
// Shared constants and types for the drive fault supervisor.
// Assumes a single 125 MHz system clock; all times are whole milliseconds.
package dfs_pkg;

   // Clock rate and derived cycles per millisecond
   localparam int unsigned CLK_HZ     = 125_000_000;
   localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;

   // Indicator and supervision times, in milliseconds
   localparam int unsigned FLASH_ON_MS  = 250;
   localparam int unsigned FLASH_OFF_MS = 250;
   localparam int unsigned PAUSE_MS     = 1500;
   localparam int unsigned FLICKER_MS   = 20;
   localparam int unsigned LOCK_MS      = 500;

   // Same times in clock cycles
   localparam int unsigned FLASH_ON_CYC  = FLASH_ON_MS * CYC_PER_MS;
   localparam int unsigned FLASH_OFF_CYC = FLASH_OFF_MS * CYC_PER_MS;
   localparam int unsigned PAUSE_CYC     = PAUSE_MS * CYC_PER_MS;
   localparam int unsigned FLICKER_CYC   = FLICKER_MS * CYC_PER_MS;
   localparam int unsigned LOCK_CYC      = LOCK_MS * CYC_PER_MS;

   // Counter width for all timers
   localparam int CNT_W = 32;

   // Fault codes, equal to the red flash count
   typedef logic [2:0] dfs_code_t;
   localparam dfs_code_t CODE_NONE = 3'h0;
   localparam dfs_code_t CODE_OC   = 3'h1;
   localparam dfs_code_t CODE_OV   = 3'h2;
   localparam dfs_code_t CODE_UV   = 3'h3;
   localparam dfs_code_t CODE_OT   = 3'h4;
   localparam dfs_code_t CODE_FB   = 3'h5;
   localparam dfs_code_t CODE_SYS  = 3'h6;

   // Bit positions in the synchronised pin vector
   localparam int PIN_EN_N = 0;
   localparam int PIN_HALL = 1;
   localparam int PIN_OC   = 2;
   localparam int PIN_OV   = 3;
   localparam int PIN_UV   = 4;
   localparam int PIN_OT   = 5;
   localparam int PIN_FB   = 6;
   localparam int PIN_SYS  = 7;
   localparam int PIN_LIM  = 8;
   localparam int PIN_RUN  = 9;
   localparam int PIN_SPD  = 10;
   localparam int PIN_CUR  = 12;
   localparam int PIN_NUM  = 14;

   // Reset values
   localparam logic       GREEN_RST = 1'b1;
   localparam logic [1:0] JMP_RST   = 2'h0;
   localparam logic       EN_N_RST  = 1'b1;

   // Red indicator sequencer states, Gray along idle-on-off-pause
   typedef enum logic [1:0] {
      FL_IDLE  = 2'h0,
      FL_ON    = 2'h1,
      FL_OFF   = 2'h3,
      FL_PAUSE = 2'h2
   } dfs_fl_state_t;

endpackage : dfs_pkg

// ---- design/dfs_flasher.sv ----
// Red indicator sequencer: flash groups for a fault code, flicker on request otherwise.
// Assumes code and flicker come from flip-flops on the same clock.
`timescale 1ns/1ps
module dfs_flasher #(
   parameter int unsigned ON_CYC    = dfs_pkg::FLASH_ON_CYC,
   parameter int unsigned OFF_CYC   = dfs_pkg::FLASH_OFF_CYC,
   parameter int unsigned PAUSE_CYC = dfs_pkg::PAUSE_CYC,
   parameter int unsigned FLICK_CYC = dfs_pkg::FLICKER_CYC
) (
   input  wire logic              clk_sys,
   input  wire logic              reset_n,
   input  wire dfs_pkg::dfs_code_t code,
   input  wire logic              flicker,
   output logic                   led
);
   import dfs_pkg::*;

   dfs_fl_state_t      state_reg, state_next;
   logic [CNT_W-1:0]   cnt_reg, cnt_next;
   dfs_code_t          left_reg, left_next;
   logic               led_reg, led_next;

   // Next state; a cleared code ends the group at the end of the current off time
   always_comb begin
      state_next = state_reg;
      cnt_next   = cnt_reg;
      left_next  = left_reg;
      led_next   = led_reg;
      case (state_reg)
         FL_IDLE: begin
            if (code != CODE_NONE) begin
               state_next = FL_ON;
               left_next  = code;
               cnt_next   = CNT_W'(ON_CYC - 1);
               led_next   = 1'b1;
            end else if (flicker) begin
               if (cnt_reg == '0) begin
                  cnt_next = CNT_W'(FLICK_CYC - 1);
                  led_next = !led_reg;
               end else begin
                  cnt_next = cnt_reg - 1'b1;
               end
            end else begin
               cnt_next = '0; // RQ14
               led_next = 1'b0; // RQ14
            end
         end
         FL_ON: begin
            if (cnt_reg == '0) begin
               state_next = FL_OFF;
               cnt_next   = CNT_W'(OFF_CYC - 1);
               left_next  = left_reg - 1'b1;
               led_next   = 1'b0;
            end else begin
               cnt_next = cnt_reg - 1'b1;
            end
         end
         FL_OFF: begin
            if (cnt_reg != '0) begin
               cnt_next = cnt_reg - 1'b1;
            end else if (code == CODE_NONE) begin
               state_next = FL_IDLE;
            end else if (left_reg == CODE_NONE) begin
               state_next = FL_PAUSE; // RQ14
               cnt_next   = CNT_W'(PAUSE_CYC - 1);
            end else begin
               state_next = FL_ON;
               cnt_next   = CNT_W'(ON_CYC - 1);
               led_next   = 1'b1;
            end
         end
         default: begin
            if (cnt_reg == '0) begin
               state_next = FL_IDLE;
            end else begin
               cnt_next = cnt_reg - 1'b1;
            end
         end
      endcase
   end

   // Sequencer registers
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         state_reg <= FL_IDLE;
         cnt_reg   <= '0;
         left_reg  <= CODE_NONE;
         led_reg   <= 1'b0;
      end else begin
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
         left_reg  <= left_next;
         led_reg   <= led_next;
      end
   end

   assign led = led_reg;

   // Dark with nothing to show
   a_dark_idle : assert property ( // RQ14
      @(posedge clk_sys) disable iff (!reset_n)
      (state_reg == FL_IDLE && code == CODE_NONE && !flicker)
      |=> !led_reg)
      else $error("red indicator lit with no fault");

   // A new code starts a flash at once
   a_group_start : assert property ( // RQ3
      @(posedge clk_sys) disable iff (!reset_n)
      (state_reg == FL_IDLE && code != CODE_NONE)
      |=> led_reg && state_reg == FL_ON)
      else $error("flash group did not start");

   // Group end is followed by a dark pause
   a_pause_dark : assert property ( // RQ14
      @(posedge clk_sys) disable iff (!reset_n)
      (state_reg == FL_PAUSE) |-> !led_reg)
      else $error("indicator lit during pause");

   c_pause : cover property (@(posedge clk_sys) disable iff (!reset_n)
      state_reg == FL_OFF ##1 state_reg == FL_PAUSE);

endmodule : dfs_flasher

// ---- design/dfs_supervisor.sv ----
// Drive fault supervisor: latches faults, gates the output stage,
// drives fault, indicator and speed pulse outputs, captures jumpers.
// Assumes all inputs are asynchronous pins from sensing circuits.
//
// Operation
// (RQ1) Jumper limits are captured only on an enable toggle.
// (RQ2) Any latched code one to six disables drive; codes one to five clear on an enable toggle.
// (RQ3) Overcurrent asserts fault output, red flash group of one.
// (RQ4) Supply over-voltage asserts fault output, red flash group of two.
// (RQ5) Supply under-voltage asserts fault output, red flash group of three.
// (RQ6) Board over-temperature asserts fault output, red flash group of four.
// (RQ7) Missing or invalid feedback asserts fault output, group of five.
// (RQ8) Locked rotor while commanded reports the same code five.
// (RQ9) Processor fault asserts fault output, group of six, power cycle.
// (RQ10) User current limit flickers red, fault output and drive untouched.
// (RQ11) Green indicator stays lit while powered.
// (RQ12) Speed pulse output rate follows motor speed.
// (RQ13) Host holds enable high to disable, low to run.
// (RQ14) No fault means dark red and no fault output; groups pause.
`timescale 1ns/1ps
module dfs_supervisor #(
   parameter int unsigned LOCK_CYCLES  = dfs_pkg::LOCK_CYC,
   parameter int unsigned ON_CYCLES    = dfs_pkg::FLASH_ON_CYC,
   parameter int unsigned OFF_CYCLES   = dfs_pkg::FLASH_OFF_CYC,
   parameter int unsigned PAUSE_CYCLES = dfs_pkg::PAUSE_CYC,
   parameter int unsigned FLICK_CYCLES = dfs_pkg::FLICKER_CYC
) (
   input  wire logic       clk_sys,
   input  wire logic       reset_n,
   input  wire logic       enable_n,
   input  wire logic       hall_in,
   input  wire logic       oc_det,
   input  wire logic       ov_det,
   input  wire logic       uv_det,
   input  wire logic       ot_det,
   input  wire logic       fb_bad_det,
   input  wire logic       sys_fault_det,
   input  wire logic       cur_lim_det,
   input  wire logic       run_cmd,
   input  wire logic [1:0] speed_jmp,
   input  wire logic [1:0] cur_jmp,
   output logic            drive_en,
   output logic            fault_out,
   output logic            led_red,
   output logic            led_green,
   output logic            tach_out,
   output logic [1:0]      speed_sel,
   output logic [1:0]      cur_sel
);
   import dfs_pkg::*;

   logic [PIN_NUM-1:0] pin_raw;
   logic [PIN_NUM-1:0] sync1_reg;
   logic [PIN_NUM-1:0] sync2_reg;

   logic               en_n_s, hall_s;
   logic               en_prev_reg, hall_prev_reg;
   logic               en_toggle, hall_edge;

   dfs_code_t          code_reg, code_next;
   logic               drive_en_reg, drive_en_next;
   logic               fault_reg, fault_next;
   logic               lim_reg, lim_next;
   logic [1:0]         spd_reg, spd_next;
   logic [1:0]         cur_reg, cur_next;
   logic               tach_reg, tach_next;
   logic               green_reg;
   logic [CNT_W-1:0]   lock_cnt_reg, lock_cnt_next;
   logic               lock_hit;

   // Gather pins so one loop can synchronise them all
   assign pin_raw[PIN_EN_N] = enable_n;
   assign pin_raw[PIN_HALL] = hall_in;
   assign pin_raw[PIN_OC]   = oc_det;
   assign pin_raw[PIN_OV]   = ov_det;
   assign pin_raw[PIN_UV]   = uv_det;
   assign pin_raw[PIN_OT]   = ot_det;
   assign pin_raw[PIN_FB]   = fb_bad_det;
   assign pin_raw[PIN_SYS]  = sys_fault_det;
   assign pin_raw[PIN_LIM]  = cur_lim_det;
   assign pin_raw[PIN_RUN]  = run_cmd;
   assign pin_raw[PIN_SPD+1:PIN_SPD] = speed_jmp;
   assign pin_raw[PIN_CUR+1:PIN_CUR] = cur_jmp;

   // Two-stage synchroniser per pin; enable idles high (drive off)
   for (genvar i = 0; i < PIN_NUM; i++) begin : g_sync
      localparam logic RST_V = (i == PIN_EN_N) ? EN_N_RST : 1'b0;
      always_ff @(posedge clk_sys or negedge reset_n) begin
         if (!reset_n) begin
            sync1_reg[i] <= RST_V;
            sync2_reg[i] <= RST_V;
         end else begin
            sync1_reg[i] <= pin_raw[i];
            sync2_reg[i] <= sync1_reg[i];
         end
      end
   end

   assign en_n_s = sync2_reg[PIN_EN_N];
   assign hall_s = sync2_reg[PIN_HALL];

   // Enable toggle: off-to-on transition of the active-low input
   assign en_toggle = en_prev_reg && !en_n_s; // RQ13
   assign hall_edge = hall_prev_reg != hall_s;

   // Locked rotor: commanded and running but no hall transitions
   assign lock_hit = lock_cnt_reg == CNT_W'(LOCK_CYCLES - 1);

   always_comb begin
      lock_cnt_next = lock_cnt_reg;
      if (!drive_en_reg || !sync2_reg[PIN_RUN] || hall_edge) begin
         lock_cnt_next = '0;
      end else if (!lock_hit) begin
         lock_cnt_next = lock_cnt_reg + 1'b1; // RQ8
      end
   end

   // Fault latch; a new fault in the clearing cycle still latches
   always_comb begin
      code_next = code_reg;
      if (en_toggle && code_reg != CODE_SYS) begin
         code_next = CODE_NONE; // RQ2
      end
      if (code_next == CODE_NONE) begin
         if (sync2_reg[PIN_OC]) begin
            code_next = CODE_OC; // RQ3
         end else if (sync2_reg[PIN_OV]) begin
            code_next = CODE_OV; // RQ4
         end else if (sync2_reg[PIN_UV]) begin
            code_next = CODE_UV; // RQ5
         end else if (sync2_reg[PIN_OT]) begin
            code_next = CODE_OT; // RQ6
         end else if (sync2_reg[PIN_FB] || lock_hit) begin
            code_next = CODE_FB; // RQ7 RQ8
         end else if (sync2_reg[PIN_SYS]) begin
            code_next = CODE_SYS; // RQ9
         end
      end
   end

   // Output stage gate, fault output and flicker request
   always_comb begin
      drive_en_next = !en_n_s && (code_next == CODE_NONE); // RQ2
      fault_next    = code_next != CODE_NONE; // RQ14
      lim_next      = sync2_reg[PIN_LIM] && (code_next == CODE_NONE);
   end

   // Jumpers only take effect on an enable toggle
   always_comb begin
      spd_next = spd_reg;
      cur_next = cur_reg;
      if (en_toggle) begin
         spd_next = sync2_reg[PIN_SPD+1:PIN_SPD]; // RQ1
         cur_next = sync2_reg[PIN_CUR+1:PIN_CUR]; // RQ1
      end
   end

   // Speed pulse: toggles on every hall transition
   always_comb begin
      tach_next = hall_edge ? !tach_reg : tach_reg; // RQ12
   end

   // State registers
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         en_prev_reg   <= EN_N_RST;
         hall_prev_reg <= 1'b0;
         code_reg      <= CODE_NONE;
         drive_en_reg  <= 1'b0;
         fault_reg     <= 1'b0;
         lim_reg       <= 1'b0;
         spd_reg       <= JMP_RST;
         cur_reg       <= JMP_RST;
         tach_reg      <= 1'b0;
         lock_cnt_reg  <= '0;
         green_reg     <= GREEN_RST;
      end else begin
         en_prev_reg   <= en_n_s;
         hall_prev_reg <= hall_s;
         code_reg      <= code_next;
         drive_en_reg  <= drive_en_next;
         fault_reg     <= fault_next;
         lim_reg       <= lim_next;
         spd_reg       <= spd_next;
         cur_reg       <= cur_next;
         tach_reg      <= tach_next;
         lock_cnt_reg  <= lock_cnt_next;
         green_reg     <= GREEN_RST; // RQ11
      end
   end

   // Red indicator sequencer; its output is a flip-flop
   dfs_flasher #(
      .ON_CYC    (ON_CYCLES),
      .OFF_CYC   (OFF_CYCLES),
      .PAUSE_CYC (PAUSE_CYCLES),
      .FLICK_CYC (FLICK_CYCLES)
   ) u_flasher (
      .clk_sys (clk_sys),
      .reset_n (reset_n),
      .code    (code_reg),
      .flicker (lim_reg), // RQ10
      .led     (led_red)
   );

   assign drive_en  = drive_en_reg;
   assign fault_out = fault_reg;
   assign led_green = green_reg;
   assign tach_out  = tach_reg;
   assign speed_sel = spd_reg;
   assign cur_sel   = cur_reg;

   // Checks on fault handling, indicators and jumper capture
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);

   a_jmp_hold : assert property ( // RQ1
      !en_toggle |=> $stable(spd_reg) && $stable(cur_reg))
      else $error("jumper selection changed without toggle");

   a_drive_off : assert property ( // RQ2
      code_reg != CODE_NONE |-> !drive_en_reg)
      else $error("drive enabled with fault latched");

   a_oc_latch : assert property ( // RQ3
      sync2_reg[PIN_OC] && code_reg == CODE_NONE
      |=> code_reg == CODE_OC && fault_reg)
      else $error("overcurrent not latched as code one");

   a_ov_latch : assert property ( // RQ4
      sync2_reg[PIN_OV] && !sync2_reg[PIN_OC] && code_reg == CODE_NONE
      |=> code_reg == CODE_OV && fault_reg)
      else $error("over-voltage not latched as code two");

   a_uv_latch : assert property ( // RQ5
      sync2_reg[PIN_UV] && sync2_reg[PIN_OV:PIN_OC] == 2'h0
      && code_reg == CODE_NONE
      |=> code_reg == CODE_UV && fault_reg)
      else $error("under-voltage not latched as code three");

   a_ot_latch : assert property ( // RQ6
      sync2_reg[PIN_OT] && sync2_reg[PIN_UV:PIN_OC] == 3'h0
      && code_reg == CODE_NONE
      |=> code_reg == CODE_OT && fault_reg)
      else $error("over-temperature not latched as code four");

   a_fb_latch : assert property ( // RQ7
      sync2_reg[PIN_FB] && sync2_reg[PIN_OT:PIN_OC] == 4'h0
      && code_reg == CODE_NONE
      |=> code_reg == CODE_FB && fault_reg)
      else $error("feedback fault not latched as code five");

   a_lock_latch : assert property ( // RQ8
      lock_hit && drive_en_reg && sync2_reg[PIN_RUN] && !hall_edge
      && sync2_reg[PIN_OT:PIN_OC] == 4'h0
      |=> code_reg == CODE_FB && !drive_en_reg)
      else $error("locked rotor not reported as code five");

   a_sys_sticky : assert property ( // RQ9
      code_reg == CODE_SYS |=> code_reg == CODE_SYS)
      else $error("processor fault cleared without power cycle");

   a_lim_quiet : assert property ( // RQ10
      code_reg == CODE_NONE && sync2_reg[PIN_LIM]
      && sync2_reg[PIN_SYS:PIN_OC] == 6'h00 && !lock_hit
      |=> !fault_reg && code_reg == CODE_NONE && lim_reg)
      else $error("current limit tripped the fault output");

   a_green_lit : assert property ( // RQ11
      ##1 led_green)
      else $error("green indicator dark while powered");

   a_tach_edge : assert property ( // RQ12
      hall_edge |=> tach_reg != $past(tach_reg))
      else $error("speed pulse missed a hall transition");

   a_no_fault : assert property ( // RQ14
      code_reg == CODE_NONE |-> !fault_reg)
      else $error("fault output set with no fault");

   c_oc_trip : cover property (
      code_reg == CODE_NONE ##1 code_reg == CODE_OC);
   c_clear : cover property (
      code_reg == CODE_OT ##1 en_toggle ##1 code_reg == CODE_NONE);
   c_lock : cover property (lock_hit ##1 code_reg == CODE_FB);
   c_flicker : cover property (lim_reg && $rose(led_red));

endmodule : dfs_supervisor

// ---- test/dfs_host_model.sv ----
// Host controller model: drives the active-low enable pin, watches fault.
// Assumes the bench sets run_req just after a rising clock edge.
`timescale 1ns/1ps
module dfs_host_model #(
   parameter int unsigned LAG = 1
) (
   input  wire logic clk_sys,
   input  wire logic reset_n,
   input  wire logic run_req,
   input  wire logic fault_out,
   output logic      enable_n
);
   logic [7:0] lag_q;
   logic       fault_q;
   int         fault_events;

   // Request passes a short lag so the host can answer slowly
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         lag_q        <= 8'h00;
         fault_q      <= 1'b0;
         fault_events <= 0;
         enable_n     <= 1'b1;
      end else begin
         lag_q    <= {lag_q[6:0], run_req};
         fault_q  <= fault_out;
         enable_n <= #1 !lag_q[LAG-1];
         if (fault_out && !fault_q) begin
            fault_events <= fault_events + 1;
         end
      end
   end
endmodule : dfs_host_model

// ---- test/dfs_supervisor_tb.sv ----
// Self-checking bench for the drive fault supervisor.
// Assumes shortened timer parameters and the host model on enable.
`timescale 1ns/1ps
module dfs_supervisor_tb;
   import dfs_pkg::*;
   localparam int unsigned LOCK_N  = 40;
   localparam int unsigned ON_N    = 4;
   localparam int unsigned OFF_N   = 4;
   localparam int unsigned PAUSE_N = 12;
   localparam int unsigned FLICK_N = 3;

   logic       clk_sys, reset_n, run_req, enable_n, hall_in;
   logic       run_cmd, cur_lim_det, tach_q;
   logic [5:0] det;
   logic [1:0] speed_jmp, cur_jmp, speed_sel, cur_sel, sj, cj;
   logic       drive_en, fault_out, led_red, led_green, tach_out;
   int         fails, num_checks, n, k, tach_edges, ev;

   dfs_supervisor #(.LOCK_CYCLES(LOCK_N), .ON_CYCLES(ON_N),
      .OFF_CYCLES(OFF_N), .PAUSE_CYCLES(PAUSE_N),
      .FLICK_CYCLES(FLICK_N)) uut (
      .clk_sys(clk_sys), .reset_n(reset_n), .enable_n(enable_n),
      .hall_in(hall_in), .oc_det(det[0]), .ov_det(det[1]),
      .uv_det(det[2]), .ot_det(det[3]), .fb_bad_det(det[4]),
      .sys_fault_det(det[5]), .cur_lim_det(cur_lim_det),
      .run_cmd(run_cmd), .speed_jmp(speed_jmp), .cur_jmp(cur_jmp),
      .drive_en(drive_en), .fault_out(fault_out), .led_red(led_red),
      .led_green(led_green), .tach_out(tach_out),
      .speed_sel(speed_sel), .cur_sel(cur_sel));

   dfs_host_model #(.LAG(2)) u_host (
      .clk_sys(clk_sys), .reset_n(reset_n), .run_req(run_req),
      .fault_out(fault_out), .enable_n(enable_n));

   // Free-running system clock, 8 ns
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end

   // Counts speed pulse edges on the falling edge, away from updates
   always @(negedge clk_sys) begin
      if (reset_n && tach_out !== tach_q) tach_edges++;
      tach_q = tach_out;
   end

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
      end
   endtask : check

   task automatic wrap_up();
      if (fails == 0 && num_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : wrap_up

   task automatic cyc(input int c);
      repeat (c) @(posedge clk_sys);
      #1;
   endtask : cyc

   task automatic do_reset();
      reset_n = 1'b0;
      cyc(4);
      reset_n = 1'b1;
   endtask : do_reset

   // Host takes enable away, then back: off long enough to sync
   task automatic toggle_en();
      run_req = 1'b0;
      cyc(4);
      run_req = 1'b1;
      cyc(9);
   endtask : toggle_en

   // Counts red rises until a dark run longer than one off gap
   task automatic count_red(input int lim, output int cnt);
      int  low;
      logic prev;
      cnt  = 0;
      low  = 0;
      prev = led_red;
      for (int i = 0; i < lim && !(cnt > 0 && low > OFF_N + 2); i++) begin
         cyc(1);
         if (led_red === 1'b1 && prev !== 1'b1) cnt++;
         low  = (led_red === 1'b1) ? 0 : low + 1;
         prev = led_red;
      end
   endtask : count_red

   // Flash count expected for scenario f; index 6 is a locked rotor
   function automatic int exp_flash(input int f);
      return (f == 6) ? 5 : f + 1;
   endfunction : exp_flash

   initial begin
      #240000;
      fails++;
      wrap_up();
   end

   initial begin
      fails = 0;
      num_checks = 0;
      tach_edges = 0;
      tach_q = 1'b0;
      k = $urandom(32'hBAFF);
      reset_n = 1'b0;
      run_req = 1'b1;
      hall_in = 1'b0;
      run_cmd = 1'b0;
      cur_lim_det = 1'b0;
      det = 6'h00;
      sj = 2'($urandom);
      cj = 2'($urandom);
      speed_jmp = sj;
      cur_jmp = cj;
      cyc(1);
      check(8'(drive_en), 8'h00);
      check(8'(led_green), 8'h01);
      cyc(3);
      reset_n = 1'b1;
      cyc(10);
      check(8'({led_red, fault_out}), 8'h00);
      check(8'(drive_en), 8'h01);
      check(8'({speed_sel, cur_sel}), 8'({sj, cj}));
      // New jumpers must wait for the next enable toggle
      speed_jmp = sj ^ 2'(1 + $urandom % 3);
      cur_jmp = cj ^ 2'h3;
      cyc(12);
      check(8'({speed_sel, cur_sel}), 8'({sj, cj}));
      toggle_en();
      check(8'({speed_sel, cur_sel}), 8'({speed_jmp, cur_jmp}));
      // Moving rotor under command: pulses follow hall, no lock fault
      run_cmd = 1'b1;
      n = tach_edges;
      for (int i = 0; i < 20; i++) begin
         hall_in = ~hall_in;
         cyc(3 + $urandom % 4);
      end
      cyc(5);
      check(8'(tach_edges - n), 8'h14);
      check(8'(fault_out), 8'h00);
      run_cmd = 1'b0;
      // User current limit: flicker only, drive keeps running
      cur_lim_det = 1'b1;
      count_red(30, n);
      check(8'(n >= 3), 8'h01);
      check(8'({fault_out, drive_en}), 8'h01);
      cur_lim_det = 1'b0;
      cyc(10);
      check(8'(led_red), 8'h00);
      // Every fault code, plus a stalled rotor
      for (int f = 0; f < 7; f++) begin
         // Host should see exactly one rise of fault per scenario
         ev = u_host.fault_events;
         if (f == 6) run_cmd = 1'b1;
         else det[f] = 1'b1;
         for (k = 0; k < LOCK_N + 12 && fault_out !== 1'b1; k++) cyc(1);
         det = 6'h00;
         run_cmd = 1'b0;
         check(8'({fault_out, drive_en}), 8'h02);
         count_red(120, n);
         check(8'(n), 8'(exp_flash(f)));
         count_red(120, n);
         check(8'(n), 8'(exp_flash(f)));
         check(8'(u_host.fault_events - ev), 8'h01);
         check(8'({fault_out, drive_en}), 8'h02);
         check(8'(led_green), 8'h01);
         toggle_en();
         if (f == 5) begin
            check(8'(fault_out), 8'h01);
            do_reset();
            cyc(10);
            // Enable going low after release acts as a toggle and loads jumpers
            check(8'({speed_sel, cur_sel}), 8'({speed_jmp, cur_jmp}));
         end
         check(8'({fault_out, drive_en}), 8'h01);
         cyc(PAUSE_N + 6 * (ON_N + OFF_N));
         check(8'(led_red), 8'h00);
      end
      wrap_up();
   end
endmodule : dfs_supervisor_tb
